/* File: ebct_periph_model.sv */
`timescale 1ns/100ps
module ebct_periph_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic [7:0] lat,
   output logic ready_b
);
   logic [7:0] wait_reg;
   // lat of ff means the peripheral never answers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_reg <= 8'h00;
         ready_b <= 1'b1;
      end else if (rd_b && wr_b) begin
         wait_reg <= 8'h00;
         ready_b <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 8'h01;
         ready_b <= (lat == 8'hff) || (wait_reg < lat);
      end
   end
endmodule // ebct_periph_model

/* File: ebct_pkg.sv */
package ebct_pkg;
   localparam int unsigned EBCT_ADDR_W = 24;
   localparam int unsigned EBCT_CFG_W = 16;
   localparam int unsigned EBCT_NUM_WIN = 4;
   // field positions, identical in all five configuration words
   localparam int unsigned EBCT_WS_LSB = 0;
   localparam int unsigned EBCT_WS_MSB = 3;
   localparam int unsigned EBCT_CMD_DLY_BIT = 4;
   localparam int unsigned EBCT_EARLY_WR_BIT = 8;
   localparam int unsigned EBCT_WIN_ACT_BIT = 10;
   localparam int unsigned EBCT_RDY_EN_BIT = 12;
   localparam logic [15:0] EBCT_CFG_RST = 16'h0000;
   localparam logic [3:0] EBCT_WS_MAX = 4'hf;
   // one cpu clock is two clk cycles, each clk cycle is one half-clock phase
   localparam logic [4:0] EBCT_PHASES_PER_WS = 5'h02;
   localparam logic [4:0] EBCT_FIXED_PHASES = 5'h01;

   typedef enum logic [8:0] {
      EBCT_ST_IDLE = 9'h001,
      EBCT_ST_ALE_A = 9'h002,
      EBCT_ST_ALE_B = 9'h004,
      EBCT_ST_CMD = 9'h008,
      EBCT_ST_RDY_A = 9'h010,
      EBCT_ST_RDY_B = 9'h020,
      EBCT_ST_SYNC_A = 9'h040,
      EBCT_ST_FIN = 9'h080,
      EBCT_ST_SPARE = 9'h100
   } ebct_state_t;
endpackage

/* File: ebct_ready_sync.sv */
`timescale 1ns/100ps
module ebct_ready_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin_in,
   output logic level_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   // a change counts only once the second and third stages agree
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         level_out <= 1'b1;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
         end
      end
   end
endmodule // ebct_ready_sync

/* File: ebct_top.sv */
`timescale 1ns/100ps
module ebct_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cyc_req,
   input wire logic [ebct_pkg::EBCT_ADDR_W-1:0] cyc_addr,
   input wire logic cyc_write,
   input wire logic [ebct_pkg::EBCT_NUM_WIN-1:0][ebct_pkg::EBCT_CFG_W-1:0] window_bus_config,
   input wire logic [ebct_pkg::EBCT_NUM_WIN-1:0][ebct_pkg::EBCT_ADDR_W-1:0] window_range_base,
   input wire logic [ebct_pkg::EBCT_NUM_WIN-1:0][ebct_pkg::EBCT_ADDR_W-1:0] window_range_mask,
   input wire logic [ebct_pkg::EBCT_CFG_W-1:0] boot_config_port,
   input wire logic default_cfg_wr,
   input wire logic [ebct_pkg::EBCT_CFG_W-1:0] default_cfg_wdata,
   input wire logic ready_b,
   output logic ale,
   output logic rd_b,
   output logic wr_b,
   output logic wdata_oe,
   output logic cyc_busy,
   output logic cyc_done,
   output logic [2:0] cyc_window,
   output logic [ebct_pkg::EBCT_CFG_W-1:0] default_bus_config
);
   import ebct_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // field helpers, shared by every configuration word

   function automatic logic [3:0] cfg_ws(input logic [EBCT_CFG_W-1:0] c);
      cfg_ws = c[EBCT_WS_MSB:EBCT_WS_LSB];
   endfunction

   function automatic logic cfg_bit(input logic [EBCT_CFG_W-1:0] c, input int unsigned pos);
      cfg_bit = c[pos];
   endfunction

   function automatic logic win_hit(input logic [EBCT_ADDR_W-1:0] a,
                                    input logic [EBCT_ADDR_W-1:0] base,
                                    input logic [EBCT_ADDR_W-1:0] mask,
                                    input logic [EBCT_CFG_W-1:0] c);
      win_hit = cfg_bit(c, EBCT_WIN_ACT_BIT) && ((a & mask) == (base & mask));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // ready pin conditioning

   logic ready_lvl;

   ebct_ready_sync u_ready_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin_in(ready_b),
      .level_out(ready_lvl)
   );

   // ready is active low; the far end holds it until the command rises
   wire ready_seen = !ready_lvl;

   ////////////////////////////////////////////////////////////////////////////////
   // default configuration word

   logic boot_done_reg;
   logic [EBCT_CFG_W-1:0] default_cfg_reg;

   // strap is caught by a clocked edge after reset release, never by the reset itself
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         boot_done_reg <= 1'b0;
         default_cfg_reg <= EBCT_CFG_RST;
      end else if (!boot_done_reg) begin
         boot_done_reg <= 1'b1;
         default_cfg_reg <= boot_config_port;
      end else if (default_cfg_wr) begin
         default_cfg_reg <= default_cfg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // window selection; lowest numbered hit wins if ranges overlap

   logic [EBCT_NUM_WIN-1:0] hit_vec;
   genvar gi;
   generate
      for (gi = 0; gi < EBCT_NUM_WIN; gi++) begin : g_hit
         assign hit_vec[gi] = win_hit(cyc_addr, window_range_base[gi],
                                      window_range_mask[gi], window_bus_config[gi]);
      end
   endgenerate

   wire [2:0] sel_win = hit_vec[0] ? 3'h1 :
                        hit_vec[1] ? 3'h2 :
                        hit_vec[2] ? 3'h3 :
                        hit_vec[3] ? 3'h4 : 3'h0;

   wire [EBCT_CFG_W-1:0] sel_cfg = hit_vec[0] ? window_bus_config[0] :
                                   hit_vec[1] ? window_bus_config[1] :
                                   hit_vec[2] ? window_bus_config[2] :
                                   hit_vec[3] ? window_bus_config[3] :
                                   default_cfg_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // per-cycle settings latched at request time

   ebct_state_t state_reg;
   ebct_state_t state_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic write_reg;
   logic dly_reg;
   logic early_reg;
   logic rdy_en_reg;
   logic rdy_async_reg;
   logic [4:0] cmd_len_reg;
   logic [2:0] win_reg;

   wire [3:0] sel_ws = cfg_ws(sel_cfg);
   wire sel_rdy_en = cfg_bit(sel_cfg, EBCT_RDY_EN_BIT);
   // ready mode: low three bits count waitstates, msb picks ready type
   // fixed mode: fifteen minus the field
   wire [3:0] sel_nws = sel_rdy_en ? {1'b0, sel_ws[2:0]} : (EBCT_WS_MAX - sel_ws);
   wire [4:0] sel_ws_ph = 5'(sel_nws) * EBCT_PHASES_PER_WS;
   // ready cycles spend their last fixed phase in the ready sampling states
   wire [4:0] sel_cmd_len = sel_rdy_en ? sel_ws_ph : 5'(sel_ws_ph + EBCT_FIXED_PHASES);

   wire take_req = (state_reg == EBCT_ST_IDLE) && cyc_req && boot_done_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         write_reg <= 1'b0;
         dly_reg <= 1'b0;
         early_reg <= 1'b0;
         rdy_en_reg <= 1'b0;
         rdy_async_reg <= 1'b0;
         cmd_len_reg <= 5'h00;
         win_reg <= 3'h0;
      end else if (take_req) begin
         write_reg <= cyc_write;
         dly_reg <= !cfg_bit(sel_cfg, EBCT_CMD_DLY_BIT);
         early_reg <= cfg_bit(sel_cfg, EBCT_EARLY_WR_BIT);
         rdy_en_reg <= sel_rdy_en;
         rdy_async_reg <= sel_ws[3];
         cmd_len_reg <= sel_cmd_len;
         win_reg <= sel_win;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // cycle sequencer, one state step per half-clock phase

   wire cmd_last = (cnt_reg == 5'h01);
   wire after_cmd_rdy = rdy_en_reg;
   wire sync_hit = rdy_en_reg && !rdy_async_reg && ready_seen;
   wire async_hit = rdy_en_reg && rdy_async_reg && ready_seen;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         EBCT_ST_IDLE: begin
            if (take_req) begin
               state_next = EBCT_ST_ALE_A;
            end
         end
         EBCT_ST_ALE_A: begin
            state_next = EBCT_ST_ALE_B;
         end
         EBCT_ST_ALE_B: begin
            cnt_next = cmd_len_reg;
            if (cmd_len_reg == 5'h00) begin
               state_next = EBCT_ST_RDY_A;
            end else begin
               state_next = EBCT_ST_CMD;
            end
         end
         EBCT_ST_CMD: begin
            cnt_next = 5'(cnt_reg - 5'h01);
            if (cmd_last) begin
               // ready is only watched once the waitstates are done
               state_next = after_cmd_rdy ? EBCT_ST_RDY_A : EBCT_ST_FIN;
            end
         end
         EBCT_ST_RDY_A: begin
            // synchronous ready: sample point in the first phase of a clock
            state_next = sync_hit ? EBCT_ST_FIN : EBCT_ST_RDY_B;
         end
         EBCT_ST_RDY_B: begin
            // asynchronous ready is sampled a phase earlier than the sync point
            // and pays one more phase, half a clock, for the synchroniser
            // no ready means loop here forever; only reset ends it
            state_next = async_hit ? EBCT_ST_SYNC_A : EBCT_ST_RDY_A;
         end
         EBCT_ST_SYNC_A: begin
            state_next = EBCT_ST_FIN;
         end
         EBCT_ST_FIN: begin
            state_next = EBCT_ST_IDLE;
         end
         default: begin
            state_next = EBCT_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= EBCT_ST_IDLE;
         cnt_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin outputs, computed from the next state so each pin is a flop matching the state

   wire ale_next = (state_next == EBCT_ST_ALE_A) || (state_next == EBCT_ST_ALE_B);
   wire post_ale_next = (state_next == EBCT_ST_CMD) || (state_next == EBCT_ST_RDY_A) ||
                        (state_next == EBCT_ST_RDY_B) || (state_next == EBCT_ST_SYNC_A) ||
                        (state_next == EBCT_ST_FIN);
   wire first_ph_next = (state_reg == EBCT_ST_ALE_B);
   // the delay only holds off the falling edge; the end of the cycle does not move
   wire cmd_on_next = post_ale_next && !(dly_reg && first_ph_next);
   wire fin_next = (state_next == EBCT_ST_FIN);
   // early write: same activation, release one phase ahead of the standard end
   wire wr_on_next = write_reg && cmd_on_next && !(early_reg && fin_next);
   wire rd_on_next = !write_reg && cmd_on_next;
   wire oe_next = write_reg && post_ale_next && !(early_reg && fin_next);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ale <= 1'b0;
         rd_b <= 1'b1;
         wr_b <= 1'b1;
         wdata_oe <= 1'b0;
         cyc_busy <= 1'b0;
         cyc_done <= 1'b0;
         cyc_window <= 3'h0;
      end else begin
         ale <= ale_next;
         rd_b <= !rd_on_next;
         wr_b <= !wr_on_next;
         wdata_oe <= oe_next;
         cyc_busy <= (state_next != EBCT_ST_IDLE);
         cyc_done <= fin_next;
         cyc_window <= take_req ? sel_win : win_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         default_bus_config <= EBCT_CFG_RST;
      end else begin
         default_bus_config <= default_cfg_reg;
      end
   end
endmodule // ebct_top

/* File: ebct_top_properties.sv */
`timescale 1ns/100ps
module ebct_top_properties
   import ebct_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [EBCT_NUM_WIN-1:0][EBCT_CFG_W-1:0] window_bus_config,
   input wire logic [EBCT_CFG_W-1:0] boot_config_port,
   input wire logic ready_b,
   input wire logic ale,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic wdata_oe,
   input wire logic cyc_busy,
   input wire logic cyc_done,
   input wire logic [2:0] cyc_window,
   input wire logic [EBCT_CFG_W-1:0] default_bus_config
);
   logic [15:0] cfg;
   logic [7:0] cnt_reg;
   // settings of the cycle in flight, picked by the reported window
   assign cfg = (cyc_window == 3'h0) ? default_bus_config : window_bus_config[cyc_window[1:0] - 2'h1];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cyc_busy ? cnt_reg + 8'h01 : 8'h00;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ale_length: assert property ($rose(ale) |=> ale ##1 !ale)
      else $error("ale high time wrong");
   // strap lands in the word on the first edge, the readback port shows it one edge later
   a_boot_load: assert property ($rose(rst_b) |=> ##1 default_bus_config == $past(boot_config_port, 2))
      else $error("default config not loaded from boot pins");
   a_fixed_count: assert property (cyc_done && !cfg[12] |-> cnt_reg == 8'h03 + {3'h0, 4'hf - cfg[3:0], 1'b0})
      else $error("fixed cycle length wrong");
   a_ready_floor: assert property (cyc_done && cfg[12] |-> cnt_reg >= 8'h03 + {4'h0, cfg[2:0], 1'b0} + {6'h00, cfg[3], 1'b0})
      else $error("ready cycle ended before its waitstates");
   a_no_timeout: assert property ((cyc_busy && cfg[12] && ready_b) [*6] |-> !cyc_done)
      else $error("ready cycle ended without ready");
   a_cmd_direct: assert property ($fell(ale) && cfg[4] |-> !(rd_b && wr_b))
      else $error("undelayed command not on ale fall");
   a_cmd_delayed: assert property ($fell(ale) && !cfg[4] |-> (rd_b && wr_b) ##1 !(rd_b && wr_b))
      else $error("delayed command not half a clock late");
   a_early_release: assert property (cyc_done && cfg[8] |-> wr_b && !wdata_oe)
      else $error("early write strobe not released in last phase");
   a_std_release: assert property (cyc_done && !cfg[8] && wdata_oe |-> !wr_b ##1 wr_b)
      else $error("standard write strobe wrong at end");
   c_ready_cycle: cover property (cyc_done && cfg[12]);
   c_delayed_cmd: cover property ($fell(ale) && !cfg[4]);
   c_early_write: cover property (cyc_done && cfg[8]);
endmodule // ebct_top_properties

bind ebct_top ebct_top_properties u_props (.clk, .rst_b, .window_bus_config, .boot_config_port,
   .ready_b, .ale, .rd_b, .wr_b, .wdata_oe, .cyc_busy, .cyc_done, .cyc_window, .default_bus_config);

/* File: ext_bus_cycle_timing_ready_test.sv */
`timescale 1ns/100ps
module ext_bus_cycle_timing_ready_test;
   import ebct_pkg::*;
   logic clk, rst_b, cyc_req, cyc_write, default_cfg_wr, ready_b, ale, rd_b, wr_b, wdata_oe;
   logic cyc_busy, cyc_done;
   logic [2:0] cyc_window;
   logic [23:0] cyc_addr;
   logic [15:0] boot_config_port, default_cfg_wdata, default_bus_config;
   logic [3:0][15:0] window_bus_config;
   logic [3:0][23:0] window_range_base, window_range_mask;
   logic [7:0] lat;
   int miscompares, num_checks, cycles;
   ebct_top DUT (.clk, .rst_b, .cyc_req, .cyc_addr, .cyc_write, .window_bus_config,
      .window_range_base, .window_range_mask, .boot_config_port, .default_cfg_wr,
      .default_cfg_wdata, .ready_b, .ale, .rd_b, .wr_b, .wdata_oe, .cyc_busy, .cyc_done,
      .cyc_window, .default_bus_config);
   ebct_periph_model peer (.clk, .rst_b, .rd_b, .wr_b, .lat, .ready_b);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (4) @(negedge clk);
      chk("strobes in reset", 16'({ale, rd_b, wr_b, wdata_oe, cyc_busy, cyc_done}), 16'h0018);
      chk("default config in reset", default_bus_config, 16'h0000);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      chk("default config after boot", default_bus_config, boot_config_port);
   endtask
   // one cycle; phases count from 1 at the first ale phase
   // lo..hi bounds the phase of the done pulse, s_at the first strobe phase
   task automatic run(input logic [23:0] a, input logic w, input int lo, input int hi,
      input int s_at, input logic ew, input logic [2:0] win);
      int n;
      int s;
      n = 1;
      s = -1;
      cyc_addr = a;
      cyc_write = w;
      cyc_req = 1'b1;
      @(negedge clk);
      cyc_req = 1'b0;
      while (cyc_done !== 1'b1 && n < 60) begin
         if (s < 0 && (rd_b & wr_b) === 1'b0) s = n;
         @(negedge clk);
         n++;
      end
      chk("cycle length", 16'(n >= lo && n <= hi), 16'h0001);
      chk("strobe start", 16'(s), 16'(s_at));
      chk("wr_b at end", 16'(wr_b), 16'(ew));
      chk("window", 16'(cyc_window), 16'(win));
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc_req = 1'b0;
      cyc_addr = 24'h000000;
      cyc_write = 1'b0;
      default_cfg_wr = 1'b0;
      default_cfg_wdata = 16'h0000;
      lat = 8'h00;
      boot_config_port = 16'h001f;
      // window 0 and the later default word keep command delay on, as software should
      window_bus_config = {16'h000f, 16'h1412, 16'h051f, 16'h040d};
      window_range_base = {24'h400000, 24'h300000, 24'h200000, 24'h100000};
      window_range_mask = {4{24'hf00000}};
      do_reset();
      run(24'h000100, 1'b0, 4, 4, 3, 1'b1, 3'h0);
      run(24'h400010, 1'b0, 4, 4, 3, 1'b1, 3'h0);
      run(24'h100020, 1'b0, 8, 8, 4, 1'b1, 3'h1);
      run(24'h200000, 1'b1, 4, 4, 3, 1'b1, 3'h2);
      window_bus_config[1] = 16'h041f;
      run(24'h200000, 1'b1, 4, 4, 3, 1'b0, 3'h2);
      run(24'h300000, 1'b0, 8, 12, 3, 1'b1, 3'h3);
      window_bus_config[2] = 16'h141a;
      run(24'h300000, 1'b1, 10, 16, 3, 1'b0, 3'h3);
      default_cfg_wdata = 16'h000c;
      default_cfg_wr = 1'b1;
      @(negedge clk);
      default_cfg_wr = 1'b0;
      @(negedge clk);
      chk("default config write", default_bus_config, 16'h000c);
      run(24'h000200, 1'b1, 10, 10, 4, 1'b0, 3'h0);
      lat = 8'hff;
      cyc_addr = 24'h300000;
      cyc_req = 1'b1;
      @(negedge clk);
      cyc_req = 1'b0;
      repeat (40) @(negedge clk);
      chk("stalled cycle", 16'({cyc_busy, cyc_done}), 16'h0002);
      do_reset();
      run(24'h000100, 1'b0, 4, 4, 3, 1'b1, 3'h0);
      results();
   end
endmodule // ext_bus_cycle_timing_ready_test
